// *** core/tlc_core.sv ***
`timescale 1ns/1ps
`include "tlc_cfg.svh"

module tlc_core #(
	parameter int unsigned SLOT_CYC = `TLC_SLOT_CYC,
	parameter int unsigned TOUT_CYC = `TLC_TOUT_CYC,
	parameter int unsigned STR_CYC  = `TLC_STR_CYC
) (
	// Clocks and reset
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        link_clk,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Converter front end
	output logic             adc_sel_o,
	input  wire logic [7:0]  adc_data_i,
	// Serial bus pins
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	// Open-drain alarm pins
	input  wire logic        int_pin_i,
	output logic             int_pin_o,
	output logic             int_pin_oe,
	input  wire logic        critical_alarm_out_i,
	output logic             critical_alarm_out_o,
	output logic             critical_alarm_out_oe
);
	tlc_pkg::tlc_temp_t local_temp_reading_q;   // Last local result
	tlc_pkg::tlc_temp_t remote_temp_reading_q;  // Last remote result
	tlc_pkg::tlc_temp_t local_high_setpoint_q;  // Local high limit
	tlc_pkg::tlc_temp_t remote_high_setpoint_q; // Remote high limit
	tlc_pkg::tlc_temp_t shared_critical_setpoint_q; // Common limit
	logic [7:0]  cfg_q;      // Mask and polarity bits
	logic [1:0]  hi_q;       // High flags: remote, local
	logic [1:0]  cr_q;       // Critical flags: remote, local
	logic [23:0] slot_q;     // Conversion slot timer
	logic        sel_q;      // Sensor being converted
	logic        conv_done;  // Slot ends, result is final
	// Write channel state
	logic        aw_got_q, w_got_q, aw_ok_q;
	logic [2:0]  aw_idx_q;
	logic [7:0]  wd_q;
	logic        wstb_q;
	logic        axi_wr;
	// Link request crossing
	logic [1:0]  rq_sy_q;    // Request toggle synchroniser
	logic        ackt_q;     // Answer toggle
	logic [7:0]  smb_rd_q;   // Answer byte, stable until next ask
	logic        req_tgl;
	logic [2:0]  req_idx;
	logic        req_we;
	logic [7:0]  req_wdata;
	logic        smb_do;
	// Shared write port
	logic        wr_en;
	logic [2:0]  wr_idx;
	logic [7:0]  wr_val;
	logic        st_rd;      // Status register is read this cycle
	logic        int_act;

	// Signed compare; temperatures below zero order correctly
	function automatic logic over(input logic [7:0] a,
		input logic [7:0] b);
		return $signed(a) > $signed(b);
	endfunction : over

	// Index is mapped
	function automatic logic mapped(input logic [2:0] idx);
		return idx <= `TLC_IDX_CFG;
	endfunction : mapped

	// Index can be written
	function automatic logic writable(input logic [2:0] idx);
		return idx == `TLC_IDX_LHS || idx == `TLC_IDX_RHS ||
			idx == `TLC_IDX_CRIT || idx == `TLC_IDX_CFG;
	endfunction : writable

	// Read mux shared by both access paths
	function automatic logic [7:0] rd_mux(input logic [2:0] idx);
		logic [7:0] v;
		v = 8'h00;
		unique case (idx)
			`TLC_IDX_LOC:  v = local_temp_reading_q;
			`TLC_IDX_REM:  v = remote_temp_reading_q;
			`TLC_IDX_LHS:  v = local_high_setpoint_q;
			`TLC_IDX_RHS:  v = remote_high_setpoint_q;
			`TLC_IDX_CRIT: v = shared_critical_setpoint_q;
			`TLC_IDX_STAT: v = {4'h0, cr_q, hi_q};
			`TLC_IDX_CFG:  v = cfg_q;
			default:       v = 8'h00;
		endcase
		return v;
	endfunction : rd_mux

	// Slot timer; each slot converts one sensor
	assign conv_done = (slot_q == 24'(SLOT_CYC - 1));
	assign adc_sel_o = sel_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			slot_q <= 24'h00_0000;
		else if (conv_done)
			slot_q <= 24'h00_0000;
		else
			slot_q <= slot_q + 24'h00_0001;
	end

	// Round robin, local first; results load only when final
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sel_q <= 1'b0;
			local_temp_reading_q <= `TLC_TEMP_RST;
			remote_temp_reading_q <= `TLC_TEMP_RST;
		end else if (conv_done) begin
			sel_q <= ~sel_q;
			if (!sel_q)
				local_temp_reading_q <= adc_data_i;
			else
				remote_temp_reading_q <= adc_data_i;
		end
	end

	// AXI write: address and data accepted in either order
	assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
	assign axi_wr = aw_got_q && w_got_q && !s_axi_bvalid;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_got_q <= 1'b0;
			aw_ok_q <= 1'b0;
			aw_idx_q <= 3'h0;
			w_got_q <= 1'b0;
			wd_q <= 8'h00;
			wstb_q <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TLC_RESP_OK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				aw_idx_q <= s_axi_awaddr[4:2];
				// Unmapped, misaligned or read-only gets an error
				aw_ok_q <= s_axi_awaddr[1:0] == 2'h0 &&
					s_axi_awaddr[7:5] == 3'h0 &&
					writable(s_axi_awaddr[4:2]);
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				wd_q <= s_axi_wdata[7:0];
				wstb_q <= s_axi_wstrb[0];
			end
			if (axi_wr) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= aw_ok_q ? `TLC_RESP_OK : `TLC_RESP_ERR;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// AXI read: one cycle from address to data
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `TLC_RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rd_mux(s_axi_araddr[4:2])};
			s_axi_rresp <= (s_axi_araddr[1:0] == 2'h0 &&
				s_axi_araddr[7:5] == 3'h0 && mapped(s_axi_araddr[4:2]))
				? `TLC_RESP_OK : `TLC_RESP_ERR;
		end else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Link request: toggle synchronised, payload held by the far side
	// An AXI write has the port first; the link ask waits a cycle
	assign smb_do = (rq_sy_q[1] ^ ackt_q) && !axi_wr;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rq_sy_q <= 2'h0;
			ackt_q <= 1'b0;
			smb_rd_q <= 8'h00;
		end else begin
			rq_sy_q <= {rq_sy_q[0], req_tgl};
			if (smb_do) begin
				ackt_q <= ~ackt_q;
				smb_rd_q <= rd_mux(req_idx);
			end
		end
	end

	// One write port for both paths
	assign wr_en = (axi_wr && aw_ok_q && wstb_q) ||
		(smb_do && req_we && writable(req_idx));
	assign wr_idx = axi_wr ? aw_idx_q : req_idx;
	assign wr_val = axi_wr ? wd_q : req_wdata;
	assign st_rd = (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == {3'h0, `TLC_IDX_STAT, 2'h0}) ||
		(smb_do && !req_we && req_idx == `TLC_IDX_STAT);

	// Setpoints and configuration
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			local_high_setpoint_q <= `TLC_SP_RST;
			remote_high_setpoint_q <= `TLC_SP_RST;
			shared_critical_setpoint_q <= `TLC_SP_RST;
			cfg_q <= `TLC_CFG_RST;
		end else if (wr_en) begin
			unique case (wr_idx)
				`TLC_IDX_LHS: local_high_setpoint_q <= wr_val;
				`TLC_IDX_RHS: remote_high_setpoint_q <= wr_val;
				`TLC_IDX_CRIT: shared_critical_setpoint_q <= wr_val;
				`TLC_IDX_CFG: cfg_q <= wr_val;
				default: cfg_q <= cfg_q;
			endcase
		end
	end

	// Flags: set at slot end, cleared by a status read only once the
	// stored reading is back within limit; a set in the same cycle wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hi_q <= 2'h0;
			cr_q <= 2'h0;
		end else begin
			hi_q[0] <= (conv_done && !sel_q &&
				over(adc_data_i, local_high_setpoint_q)) ||
				(hi_q[0] && !(st_rd && !over(local_temp_reading_q,
				local_high_setpoint_q)));
			hi_q[1] <= (conv_done && sel_q &&
				over(adc_data_i, remote_high_setpoint_q)) ||
				(hi_q[1] && !(st_rd && !over(remote_temp_reading_q,
				remote_high_setpoint_q)));
			cr_q[0] <= (conv_done && !sel_q &&
				over(adc_data_i, shared_critical_setpoint_q)) ||
				(cr_q[0] && !(st_rd && !over(local_temp_reading_q,
				shared_critical_setpoint_q)));
			cr_q[1] <= (conv_done && sel_q &&
				over(adc_data_i, shared_critical_setpoint_q)) ||
				(cr_q[1] && !(st_rd && !over(remote_temp_reading_q,
				shared_critical_setpoint_q)));
		end
	end

	// Pins pull low when asserted; polarity bit flips the interrupt
	assign int_act = (|hi_q) && !cfg_q[`TLC_CFG_MASK_B];
	assign int_pin_o = 1'b0;
	assign critical_alarm_out_o = 1'b0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			int_pin_oe <= 1'b0;
			critical_alarm_out_oe <= 1'b0;
		end else begin
			int_pin_oe <= int_act ^ cfg_q[`TLC_CFG_INV_B];
			critical_alarm_out_oe <= |cr_q;
		end
	end

	// Serial slave on the link clock
	tlc_smb_slave #(
		.TOUT_CYC (TOUT_CYC),
		.STR_CYC  (STR_CYC)
	) u_smb (
		.link_clk    (link_clk),
		.rst         (rst),
		.scl_i       (scl_i),
		.scl_o       (scl_o),
		.scl_oe      (scl_oe),
		.sda_i       (sda_i),
		.sda_o       (sda_o),
		.sda_oe      (sda_oe),
		.req_tgl_o   (req_tgl),
		.req_idx_o   (req_idx),
		.req_we_o    (req_we),
		.req_wdata_o (req_wdata),
		.ack_tgl_i   (ackt_q),
		.ack_rdata_i (smb_rd_q)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_high_set: assert property (conv_done && !sel_q &&
		over(adc_data_i, local_high_setpoint_q) |=> hi_q[0])
		else $error("local high flag missed");
	a_high_release: assert property ($fell(hi_q[0]) |->
		$past(st_rd) && !over($past(local_temp_reading_q),
		$past(local_high_setpoint_q)))
		else $error("local high flag cleared without cause");
	a_int_drive: assert property ((|hi_q) &&
		!cfg_q[`TLC_CFG_MASK_B] && !cfg_q[`TLC_CFG_INV_B] |=> int_pin_oe)
		else $error("interrupt pin not pulled");
	a_crit_path: assert property (conv_done &&
		over(adc_data_i, shared_critical_setpoint_q) |=>
		(|cr_q) ##1 critical_alarm_out_oe)
		else $error("critical alarm not raised");
	a_result_hold: assert property (!conv_done |=>
		$stable(local_temp_reading_q) && $stable(remote_temp_reading_q))
		else $error("result changed mid conversion");
	a_result_load: assert property (conv_done && !sel_q |=>
		local_temp_reading_q == $past(adc_data_i))
		else $error("local result not loaded");
	a_order_alt: assert property (conv_done |=>
		sel_q != $past(sel_q) ##0 !conv_done [*8])
		else $error("conversion order or spacing broken");

	c_high_flag: cover property ($rose(hi_q[0]));
	c_crit_alarm: cover property ($rose(critical_alarm_out_oe));
	c_link_access: cover property (smb_do && !req_we);

endmodule : tlc_core

// *** core/tlc_cfg.svh ***
`ifndef TLC_CFG_SVH
`define TLC_CFG_SVH

// Clock periods in ns
`define TLC_CLK_NS     20
`define TLC_LINK_NS    30

// Bus-low time before the serial side gives up, least value
`define TLC_TOUT_MS    25
`define TLC_TOUT_CYC   ((`TLC_TOUT_MS*1000000+`TLC_LINK_NS-1)/`TLC_LINK_NS)
// Longest total clock stretch within one message
`define TLC_STR_MS     10
`define TLC_STR_CYC    (`TLC_STR_MS*1000000/`TLC_LINK_NS)
// One pass over both sensors, split into two slots
`define TLC_PASS_MS    480
`define TLC_SLOT_CYC   (`TLC_PASS_MS*1000000/2/`TLC_CLK_NS)

// Register indices; byte address is four times the index
`define TLC_IDX_LOC    3'h0
`define TLC_IDX_REM    3'h1
`define TLC_IDX_LHS    3'h2
`define TLC_IDX_RHS    3'h3
`define TLC_IDX_CRIT   3'h4
`define TLC_IDX_STAT   3'h5
`define TLC_IDX_CFG    3'h6

// Field positions
`define TLC_CFG_MASK_B 7
`define TLC_CFG_INV_B  1
`define TLC_ST_CRIT_B  2

// Reset values
`define TLC_SP_RST     8'h7F
`define TLC_CFG_RST    8'h00
`define TLC_TEMP_RST   8'h00
`define TLC_SMB_ADDR   7'h18

// Bus answers
`define TLC_RESP_OK    2'h0
`define TLC_RESP_ERR   2'h2

`endif

// *** core/tlc_pkg.sv ***
package tlc_pkg;

	// Serial slave states, Gray along receive, ack, wait, send
	typedef enum logic [2:0] {
		SMB_IDLE = 3'h0,
		SMB_RX   = 3'h1,
		SMB_ACK  = 3'h3,
		SMB_WAIT = 3'h2,
		SMB_TX   = 3'h6,
		SMB_MACK = 3'h7
	} tlc_smb_e;

	// Temperature byte, two's complement, one degree per step
	typedef logic [7:0] tlc_temp_t;

endpackage : tlc_pkg

// *** core/tlc_smb_slave.sv ***
`timescale 1ns/1ps
`include "tlc_cfg.svh"

module tlc_smb_slave #(
	parameter int unsigned TOUT_CYC = `TLC_TOUT_CYC,
	parameter int unsigned STR_CYC  = `TLC_STR_CYC
) (
	// Link clock and reset
	input  wire logic       link_clk,
	input  wire logic       rst,
	// Serial clock pin
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oe,
	// Serial data pin
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	// Register request toward the core domain
	output logic            req_tgl_o,
	output logic [2:0]      req_idx_o,
	output logic            req_we_o,
	output logic [7:0]      req_wdata_o,
	input  wire logic       ack_tgl_i,
	input  wire logic [7:0] ack_rdata_i
);
	logic [1:0]        scl_sy_q;  // Pin synchroniser
	logic [1:0]        sda_sy_q;  // Pin synchroniser
	logic [1:0]        ack_sy_q;  // Answer toggle synchroniser
	logic              scl_d_q;   // Last synced clock level
	logic              sda_d_q;   // Last synced data level
	logic [19:0]       low_q;     // Continuous bus-low time
	logic [19:0]       str_q;     // Stretch used in this message
	tlc_pkg::tlc_smb_e st_q;      // Protocol state
	tlc_pkg::tlc_smb_e after_q;   // State to take after a wait
	logic [3:0]        cnt_q;     // Bit counter
	logic [7:0]        sr_q;      // Shift register
	logic [2:0]        ptr_q;     // Register pointer
	logic              first_q;   // Next byte is the address
	logic              cmd_q;     // Pointer byte already taken
	logic              rd_q;      // Read direction
	logic              sent_q;    // Request issued in this wait
	logic              nack_q;    // Master refused more data
	logic              scl_s, sda_s, rise, fall, start, stop;
	logic              tout, abort;

	assign scl_s = scl_sy_q[1];
	assign sda_s = sda_sy_q[1];
	assign rise  = scl_s & ~scl_d_q;
	assign fall  = ~scl_s & scl_d_q;
	assign start = scl_s & scl_d_q & sda_d_q & ~sda_s;
	assign stop  = scl_s & scl_d_q & ~sda_d_q & sda_s;
	assign tout  = (low_q == 20'(TOUT_CYC));
	assign abort = (str_q == 20'(STR_CYC));
	// Open drain: the pins only ever pull low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;

	// Two flip-flops on every pin and on the answer toggle
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			scl_sy_q <= 2'h3;
			sda_sy_q <= 2'h3;
			ack_sy_q <= 2'h0;
			scl_d_q  <= 1'b1;
			sda_d_q  <= 1'b1;
		end else begin
			scl_sy_q <= {scl_sy_q[0], scl_i};
			sda_sy_q <= {sda_sy_q[0], sda_i};
			ack_sy_q <= {ack_sy_q[0], ack_tgl_i};
			scl_d_q  <= scl_s;
			sda_d_q  <= sda_s;
		end
	end

	// Bus-low watchdog; it saturates until both lines go high
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst)
			low_q <= 20'h0_0000;
		else if (scl_s && sda_s)
			low_q <= 20'h0_0000;
		else if (!tout)
			low_q <= low_q + 20'h0_0001;
	end

	// Stretch budget, refilled at every start
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst)
			str_q <= 20'h0_0000;
		else if (start)
			str_q <= 20'h0_0000;
		else if (st_q == tlc_pkg::SMB_WAIT && !abort)
			str_q <= str_q + 20'h0_0001;
	end

	// Byte protocol; a stale answer is waited out before a new ask
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			st_q <= tlc_pkg::SMB_IDLE;
			after_q <= tlc_pkg::SMB_IDLE;
			cnt_q <= 4'h0;
			sr_q <= 8'h00;
			ptr_q <= 3'h0;
			first_q <= 1'b0;
			cmd_q <= 1'b0;
			rd_q <= 1'b0;
			sent_q <= 1'b0;
			nack_q <= 1'b0;
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
			req_tgl_o <= 1'b0;
			req_idx_o <= 3'h0;
			req_we_o <= 1'b0;
			req_wdata_o <= 8'h00;
		end else if (tout || stop || (abort && !start)) begin
			// A start refills the spent budget, so it must not be lost
			// Drop the transfer and let both lines float high
			st_q <= tlc_pkg::SMB_IDLE;
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
		end else if (start) begin
			st_q <= tlc_pkg::SMB_RX;
			cnt_q <= 4'h0;
			first_q <= 1'b1;
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
		end else begin
			unique case (st_q)
				tlc_pkg::SMB_IDLE: begin
				end
				tlc_pkg::SMB_RX: begin
					if (rise) begin
						sr_q <= {sr_q[6:0], sda_s};
						cnt_q <= cnt_q + 4'h1;
					end else if (fall && cnt_q == 4'h8) begin
						cnt_q <= 4'h0;
						first_q <= 1'b0;
						if (first_q) begin
							// Address byte; not ours means sit out
							if (sr_q[7:1] == `TLC_SMB_ADDR) begin
								rd_q <= sr_q[0];
								if (!sr_q[0])
									cmd_q <= 1'b0;
								st_q <= tlc_pkg::SMB_ACK;
								sda_oe <= 1'b1;
							end else begin
								st_q <= tlc_pkg::SMB_IDLE;
							end
						end else if (!cmd_q) begin
							ptr_q <= sr_q[2:0];
							cmd_q <= 1'b1;
							st_q <= tlc_pkg::SMB_ACK;
							sda_oe <= 1'b1;
						end else begin
							// Data byte: write it before acking
							req_we_o <= 1'b1;
							req_idx_o <= ptr_q;
							req_wdata_o <= sr_q;
							after_q <= tlc_pkg::SMB_ACK;
							sent_q <= 1'b0;
							scl_oe <= 1'b1;
							st_q <= tlc_pkg::SMB_WAIT;
						end
					end
				end
				tlc_pkg::SMB_ACK: begin
					if (fall) begin
						sda_oe <= 1'b0;
						if (rd_q) begin
							req_we_o <= 1'b0;
							req_idx_o <= ptr_q;
							after_q <= tlc_pkg::SMB_TX;
							sent_q <= 1'b0;
							scl_oe <= 1'b1;
							st_q <= tlc_pkg::SMB_WAIT;
						end else begin
							st_q <= tlc_pkg::SMB_RX;
						end
					end
				end
				tlc_pkg::SMB_WAIT: begin
					// Clock held low while the core answers
					if (!sent_q && ack_sy_q[1] == req_tgl_o) begin
						req_tgl_o <= ~req_tgl_o;
						sent_q <= 1'b1;
					end else if (sent_q && ack_sy_q[1] == req_tgl_o) begin
						scl_oe <= 1'b0;
						st_q <= after_q;
						cnt_q <= 4'h0;
						sr_q <= ack_rdata_i;
						sda_oe <= (after_q == tlc_pkg::SMB_TX) ?
							~ack_rdata_i[7] : 1'b1;
					end
				end
				tlc_pkg::SMB_TX: begin
					if (fall) begin
						cnt_q <= cnt_q + 4'h1;
						sr_q <= {sr_q[6:0], 1'b0};
						sda_oe <= (cnt_q == 4'h7) ? 1'b0 : ~sr_q[6];
						if (cnt_q == 4'h7)
							st_q <= tlc_pkg::SMB_MACK;
					end
				end
				tlc_pkg::SMB_MACK: begin
					if (rise)
						nack_q <= sda_s;
					else if (fall && nack_q)
						st_q <= tlc_pkg::SMB_IDLE;
					else if (fall) begin
						sent_q <= 1'b0;
						scl_oe <= 1'b1;
						st_q <= tlc_pkg::SMB_WAIT;
					end
				end
				default: st_q <= tlc_pkg::SMB_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge link_clk); endclocking
	default disable iff (rst);

	a_timeout_idle: assert property (tout |=>
		st_q == tlc_pkg::SMB_IDLE && !sda_oe && !scl_oe)
		else $error("serial side not idle after bus timeout");
	a_stretch_cap: assert property (abort |=> !scl_oe)
		else $error("clock still stretched past the budget");
	a_stretch_hold: assert property (
		st_q == tlc_pkg::SMB_WAIT |-> scl_oe && str_q <= 20'(STR_CYC))
		else $error("wait without stretch or budget overrun");

endmodule : tlc_smb_slave

// *** tb/tlc_smb_host.sv ***
`timescale 1ns/1ps
// Behavioural SMBus host; a set pull flag drives its line low
module tlc_smb_host (
	// Link clock
	input  wire logic link_clk,
	// Resolved bus levels
	input  wire logic scl,
	input  wire logic sda,
	// Pull-low requests
	output logic      pull_scl,
	output logic      pull_sda
);
	int n; // Stretch wait count
	bit stuck = 1'b0; // Set once a stretch outlasts the bound
	// Lines released at power up
	initial begin
		pull_scl = 1'b0;
		pull_sda = 1'b0;
	end
	// Half of a bit period
	task automatic hp();
		repeat (8) @(posedge link_clk);
	endtask : hp
	// One bit; a slave stretch is waited out, but never forever
	task automatic bit_io(input logic b, output logic r);
		pull_sda <= !b;
		hp();
		pull_scl <= 1'b0;
		n = 0;
		@(posedge link_clk);
		while (!scl && n < 90) begin
			@(posedge link_clk);
			n++;
		end
		if (n == 90)
			stuck = 1'b1;
		hp();
		r = sda;
		pull_scl <= 1'b1;
	endtask : bit_io
	// Byte MSB first, then the acknowledge bit
	task automatic byte_io(input logic [7:0] d, input logic ak,
		output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(ak, a);
	endtask : byte_io
	// Start, or repeated start from a low clock
	task automatic start();
		pull_sda <= 1'b0;
		hp();
		pull_scl <= 1'b0;
		hp();
		pull_sda <= 1'b1;
		hp();
		pull_scl <= 1'b1;
		hp();
	endtask : start
	// Stop: data rises while clock is high
	task automatic stop();
		pull_sda <= 1'b1;
		hp();
		pull_scl <= 1'b0;
		hp();
		pull_sda <= 1'b0;
		hp();
	endtask : stop
endmodule : tlc_smb_host

// *** tb/tlc_core_tb.sv ***
`timescale 1ns/1ps
module tlc_core_tb;
	logic clk = 0, lclk = 0, rst = 1; // Clocks and reset
	logic [7:0] awa = 0, ara = 0, adc = 0; // Addresses, converter
	logic [31:0] wd = 0; // Write data
	logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0; // Handshakes
	logic awr, wr, bv, arr, rv, sel, so, soe, do_, doe;
	logic io, ioe, co, coe, ps, pd; // Pin outputs, host pulls
	logic [1:0] brs, rrs; // Responses
	logic [31:0] rd; // Read data
	int num_errors = 0, n_checks = 0;
	// Open-drain wires with pull-ups
	wire scl = !(ps | soe);
	wire sda = !(pd | doe);
	always #10 clk = !clk;
	// Link clock, offset so edges never line up with clk
	initial begin
		#7;
		forever #15 lclk = !lclk;
	end
	tlc_core #(.SLOT_CYC(20), .TOUT_CYC(200), .STR_CYC(100)) dut (
		.clk(clk), .rst(rst), .link_clk(lclk),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(brs), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rrs),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .adc_sel_o(sel),
		.adc_data_i(adc), .scl_i(scl), .scl_o(so), .scl_oe(soe),
		.sda_i(sda), .sda_o(do_), .sda_oe(doe), .int_pin_i(!ioe),
		.int_pin_o(io), .int_pin_oe(ioe),
		.critical_alarm_out_i(!coe), .critical_alarm_out_o(co),
		.critical_alarm_out_oe(coe));
	tlc_smb_host host (.link_clk(lclk), .scl(scl), .sda(sda),
		.pull_scl(ps), .pull_sda(pd));
	// Verdict and end of run
	task results();
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// Write; handshakes seen at the falling edge, acted on after rise
	task axi_wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] er);
		logic ha, hw, hb;
		int k;
		@(posedge clk);
		{awa, wd, awv, wv, br} <= {a, 24'h0, d, 3'b111};
		for (k = 0; k < 50; k++) begin
			@(negedge clk);
			{ha, hw, hb} = {awv & awr, wv & wr, bv};
			@(posedge clk);
			if (ha) awv <= 0;
			if (hw) wv <= 0;
			if (hb) break;
		end
		br <= 0;
		if (k == 50) begin
			num_errors++;
			results();
		end
		chk(brs, er);
	endtask : axi_wr
	// Read, compared against the expected byte and response
	task axi_rd(input logic [7:0] a, input logic [7:0] e,
		input logic [1:0] er);
		logic ha, hb;
		int k;
		@(posedge clk);
		{ara, arv, rr} <= {a, 2'b11};
		for (k = 0; k < 50; k++) begin
			@(negedge clk);
			{ha, hb} = {arv & arr, rv};
			@(posedge clk);
			if (ha) arv <= 0;
			if (hb) break;
		end
		rr <= 0;
		if (k == 50) begin
			num_errors++;
			results();
		end
		chk(rd, {24'h0, e});
		chk(rrs, er);
	endtask : axi_rd
	// Converter byte held for both slots of a pass
	task conv(input logic [7:0] v);
		adc <= v;
		repeat (45) @(posedge clk);
	endtask : conv
	// Serial write of one register, every byte acknowledged
	task smb_wr(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		logic a;
		host.start();
		host.byte_io(8'h30, 1, r, a);
		chk(a, 0);
		host.byte_io(c, 1, r, a);
		chk(a, 0);
		host.byte_io(d, 1, r, a);
		chk(a, 0);
		host.stop();
		if (host.stuck) begin
			num_errors++;
			results();
		end
	endtask : smb_wr
	// Serial read through a repeated start
	task smb_rd(input logic [7:0] c, input logic [7:0] e);
		logic [7:0] r;
		logic a;
		host.start();
		host.byte_io(8'h30, 1, r, a);
		host.byte_io(c, 1, r, a);
		host.start();
		host.byte_io(8'h31, 1, r, a);
		host.byte_io(8'hFF, 1, r, a);
		chk(r, e);
		host.stop();
		if (host.stuck) begin
			num_errors++;
			results();
		end
	endtask : smb_rd
	// Reset values and bus refusals
	task t_regs();
		axi_rd(8'h08, 8'h7F, 0);
		axi_rd(8'h10, 8'h7F, 0);
		axi_rd(8'h14, 8'h00, 0);
		axi_wr(8'h00, 8'h12, 2);
		axi_rd(8'h00, 8'h00, 0);
		axi_rd(8'h1C, 8'h00, 2);
	endtask : t_regs
	// Slot length between sensor switches
	// Sampled at falling edges, where the select output has settled
	task t_order();
		int k;
		@(negedge clk);
		for (k = 0; k < 40 && sel; k++)
			@(negedge clk);
		for (k = 0; k < 40 && !sel; k++)
			@(negedge clk);
		for (k = 0; k < 40 && sel; k++)
			@(negedge clk);
		chk(k, 20);
	endtask : t_order
	// Signed limits, sticky flags, clear after status read
	task t_limits();
		// Converter byte set first so no slot sees the new limits at zero
		adc <= 8'hFB;
		axi_wr(8'h08, 8'h05, 0);
		axi_wr(8'h0C, 8'hFB, 0);
		axi_wr(8'h10, 8'h10, 0);
		conv(8'hFB);
		axi_rd(8'h04, 8'hFB, 0);
		chk({ioe, coe}, 0);
		conv(8'h11);
		chk({ioe, coe}, 2'b11);
		axi_wr(8'h18, 8'h80, 0);
		axi_rd(8'h18, 8'h80, 0);
		chk({ioe, coe}, 2'b01);
		axi_wr(8'h18, 8'h00, 0);
		axi_rd(8'h14, 8'h0F, 0);
		// Below both high limits, remote one included, and not critical
		conv(8'hF0);
		chk({ioe, coe}, 2'b11);
		axi_wr(8'h14, 8'h00, 2);
		axi_rd(8'h14, 8'h0F, 0);
		repeat (3) @(posedge clk);
		chk({ioe, coe}, 0);
		axi_rd(8'h14, 8'h00, 0);
		// Inverted polarity pulls the pin while no flag is set
		axi_wr(8'h18, 8'h02, 0);
		repeat (2) @(posedge clk);
		chk({ioe, coe}, 2'b10);
		axi_wr(8'h18, 8'h00, 0);
	endtask : t_limits
	// Serial access, then a hung clock that the slave must drop
	task t_smb();
		logic [7:0] r;
		logic a;
		smb_wr(8'h03, 8'h22);
		axi_rd(8'h0C, 8'h22, 0);
		smb_rd(8'h02, 8'h05);
		host.start();
		host.byte_io(8'h31, 1, r, a);
		repeat (40) @(posedge lclk);
		chk(doe, 1);
		repeat (260) @(posedge lclk);
		chk({soe, doe}, 0);
		host.stop();
		smb_rd(8'h03, 8'h22);
	endtask : t_smb
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		t_regs();
		t_order();
		t_limits();
		t_smb();
		results();
	end
endmodule : tlc_core_tb
